// [dv/wdrc_host.sv]
// Host model writing and reading the control bytes
module wdrc_host (
   // Clock
   input wire logic        sys_clk,
   // Register port
   output logic            wr_en,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic [7:0]      rd_addr,
   input wire logic [7:0]  rd_data_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      rd_addr = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(negedge sys_clk);
      wr_en = 1'b0;
      // Released bus shows the inverse so stale data never looks valid
      wr_addr = ~a;
      wr_data = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      rd_addr = a;
      @(negedge sys_clk);
      d = rd_data_ff;
   endtask
   task automatic unlock;
      wr(8'h09, 8'h00);
   endtask
endmodule // wdrc_host

// [dv/wdrc_sva.sv]
// Assertion checker for the watchdog and recovery control bytes
module wdrc_sva (
   // Clock and reset
   input wire logic                     sys_clk,
   input wire logic                     rst,
   // Register port
   input wire logic                     wr_en,
   input wire logic [7:0]               wr_addr,
   input wire logic [7:0]               wr_data,
   input wire logic [7:0]               rd_addr,
   input wire logic [7:0]               rd_data_ff,
   // Frequency change input, frequency and reset outputs
   input wire logic                     freq_change_pulse,
   input wire logic                     freq_write_lock_ff,
   input wire logic                     recovery_load_ff,
   input wire wdrc_pkg::wdrc_recovery_s recovery_ff,
   input wire logic                     sys_reset_pulse_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_lock_load;
      $rose(freq_write_lock_ff) |-> recovery_load_ff;
   endproperty
   a_lock_load: assert property (p_lock_load) else $error("lock rose without recovery load");
   property p_load_once;
      recovery_load_ff |=> !recovery_load_ff;
   endproperty
   a_load_once: assert property (p_load_once) else $error("recovery load longer than one cycle");
   property p_rst_cause;
      $rose(sys_reset_pulse_ff) |-> $past(freq_change_pulse) || recovery_load_ff;
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("reset pulse without cause");
   property p_rst_min;
      $rose(sys_reset_pulse_ff) |-> sys_reset_pulse_ff[*8];
   endproperty
   a_rst_min: assert property (p_rst_min) else $error("reset pulse too short");
   property p_rd_rsvd;
      rd_addr == 8'h07 |=> rd_data_ff == 8'h00;
   endproperty
   a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved byte not zero");
   property p_rd_ctl0;
      rd_addr == 8'h09 |=> !rd_data_ff[0];
   endproperty
   a_rd_ctl0: assert property (p_rd_ctl0) else $error("control bit 0 not zero");
   property p_rd_tmhi;
      rd_addr == 8'h08 |=> rd_data_ff[7:6] == 2'b00;
   endproperty
   a_rd_tmhi: assert property (p_rd_tmhi) else $error("timer byte top bits not zero");
   property p_lock_hold;
      freq_write_lock_ff && !wr_en && !$past(wr_en) |=> freq_write_lock_ff;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock dropped without a write");
   property p_rec_n;
      wr_en && wr_addr == 8'h0b |=> recovery_ff.recovery_n_divider == $past(wr_data);
   endproperty
   a_rec_n: assert property (p_rec_n) else $error("recovery divider not written");

   c_lock: cover property ($rose(freq_write_lock_ff));
   c_unlock: cover property ($fell(freq_write_lock_ff));
   c_rst: cover property ($rose(sys_reset_pulse_ff));
endmodule // wdrc_sva

bind wdrc_watchdog_recovery_control wdrc_sva wdrc_sva_inst (.sys_clk(sys_clk), .rst(rst), .wr_en(wr_en),
   .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data_ff(rd_data_ff),
   .freq_change_pulse(freq_change_pulse), .freq_write_lock_ff(freq_write_lock_ff),
   .recovery_load_ff(recovery_load_ff), .recovery_ff(recovery_ff), .sys_reset_pulse_ff(sys_reset_pulse_ff));

// [dv/wdrc_tb.sv]
// Self-checking bench of the watchdog and recovery control bytes
`include "wdrc_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} wdrc_row_s;
   logic       sys_clk, rst, fcp, wr_en, lock, load, rstp, rsrc;
   logic [2:0] drv;
   logic [4:0] sw, strap, ratio;
   logic [6:0] skw, rm;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data_ff, v, rn;
   int         fail_count, checked, n;
   wdrc_row_s  rows[14] = '{
      '{1'b0, 8'h08, 8'h00, 8'h3e}, '{1'b0, 8'h09, 8'h00, 8'h00}, '{1'b0, 8'h0a, 8'h00, 8'h00},
      '{1'b0, 8'h0b, 8'h00, 8'h00}, '{1'b0, 8'h0c, 8'h00, 8'h00}, '{1'b0, 8'h07, 8'h00, 8'h00},
      '{1'b1, 8'h08, 8'hff, 8'h3f}, '{1'b1, 8'h09, 8'hfd, 8'hf8}, '{1'b1, 8'h0a, 8'hff, 8'hef},
      '{1'b1, 8'h0b, 8'ha5, 8'ha5}, '{1'b1, 8'h0c, 8'hff, 8'hff}, '{1'b1, 8'h07, 8'hff, 8'h00},
      '{1'b1, 8'h09, 8'h00, 8'h00}, '{1'b1, 8'h0a, 8'h00, 8'h00}};

   wdrc_host wdrc_host_inst (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_addr(rd_addr), .rd_data_ff(rd_data_ff));
   // Short units keep each timeout within a few dozen cycles
   wdrc_watchdog_recovery_control #(.SHORT_UNIT_CYC(10), .LONG_UNIT_CYC(40)) wdrc_watchdog_recovery_control_inst (
      .sys_clk(sys_clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
      .rd_data_ff(rd_data_ff), .freq_change_pulse(fcp), .sw_freq_select(sw), .strap_freq_inputs(strap),
      .freq_write_lock_ff(lock), .recovery_load_ff(load), .recovery_ff({rsrc, rn, rm}), .ratio_select_ff(ratio),
      .sys_reset_pulse_ff(rstp), .drive_ff(drv), .skew_ff(skw));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, g, e);
      end
   endtask
   task automatic complete_run;
      $display("Counts: %0d checked, %0d failed", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic fc;
      @(negedge sys_clk);
      fcp = 1'b1;
      @(negedge sys_clk);
      fcp = 1'b0;
   endtask
   task automatic wait_load(output int k);
      k = 0;
      while (load !== 1'b1 && k < 400) begin
         @(negedge sys_clk);
         k++;
      end
   endtask
   initial begin
      #100000;
      fail_count++;
      $display("Error at %0t: run hung", $time);
      complete_run;
   end
   initial begin
      rst = 1'b1;
      fcp = 1'b0;
      sw = 5'h0a;
      strap = 5'h15;
      fail_count = 0;
      checked = 0;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) wdrc_host_inst.wr(rows[i].a, rows[i].d);
         wdrc_host_inst.rd(rows[i].a, v);
         chk(v, rows[i].e);
      end
      chk(rn, 8'ha5);
      chk({rsrc, rm}, 8'hff);
      wdrc_host_inst.wr(8'h09, 8'ha0);
      wdrc_host_inst.wr(8'h0a, 8'h96);
      chk(8'(drv), 8'h05);
      chk(8'(skw), 8'h46);
      $display("Table test done");
      // Enabled watchdog must wait for a frequency change before counting
      wdrc_host_inst.wr(8'h08, 8'h04);
      wdrc_host_inst.wr(8'h09, 8'h12);
      repeat (40) @(negedge sys_clk);
      chk(8'(lock), 8'h00);
      fc;
      wait_load(n);
      chk(8'(n >= 18 && n <= 33), 8'h01);
      chk(8'(lock), 8'h01);
      n = 0;
      while (rstp === 1'b1 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      chk(8'(n == `WDRC_RST_PULSE_CYC), 8'h01);
      wdrc_host_inst.wr(8'h05, 8'h04);
      wdrc_host_inst.rd(8'h05, v);
      chk(v, 8'ha8);
      chk(8'(ratio), 8'h15);
      wdrc_host_inst.wr(8'h09, 8'h12);
      wdrc_host_inst.rd(8'h09, v);
      chk(v, 8'h16);
      wdrc_host_inst.wr(8'h09, 8'h16);
      wdrc_host_inst.rd(8'h09, v);
      chk(v, 8'h12);
      chk(8'(lock), 8'h01);
      wdrc_host_inst.unlock;
      repeat (2) @(negedge sys_clk);
      chk(8'(lock), 8'h00);
      wdrc_host_inst.wr(8'h05, 8'h04);
      wdrc_host_inst.rd(8'h05, v);
      chk(v, 8'hac);
      chk(8'(ratio), 8'h0a);
      $display("Short timeout test done");
      // Long unit, reset pulse disabled
      wdrc_host_inst.wr(8'h08, 8'h03);
      wdrc_host_inst.wr(8'h09, 8'h02);
      fc;
      wait_load(n);
      chk(8'(n > 25 && n < 400), 8'h01);
      chk(8'(rstp), 8'h00);
      wdrc_host_inst.unlock;
      $display("Long timeout test done");
      // Reset after a frequency change only while enabled
      wdrc_host_inst.wr(8'h09, 8'h08);
      fc;
      @(negedge sys_clk);
      chk(8'(rstp), 8'h01);
      wdrc_host_inst.wr(8'h09, 8'h00);
      repeat (260) @(negedge sys_clk);
      fc;
      repeat (2) @(negedge sys_clk);
      chk(8'(rstp), 8'h00);
      $display("Frequency change test done");
      rst = 1'b1;
      #8 rst = 1'b0;
      wdrc_host_inst.rd(8'h09, v);
      chk(v, 8'h00);
      $display("Reset test done");
      complete_run;
   end
endmodule // tb

// [pkg/wdrc_params.svh]
// Constants of the watchdog and recovery control byte logic
`ifndef WDRC_PARAMS_SVH
`define WDRC_PARAMS_SVH

// ****************************************************************
// Control byte offsets
// ****************************************************************
`define WDRC_OFS_FREQ_SEL      8'h05
`define WDRC_OFS_RSVD          8'h07
`define WDRC_OFS_TIMER         8'h08
`define WDRC_OFS_WDCTL         8'h09
`define WDRC_OFS_SKEW          8'h0a
`define WDRC_OFS_REC_N         8'h0b
`define WDRC_OFS_REC_M         8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define WDRC_FS_STRAP_HI       7
`define WDRC_FS_STRAP_LO       3
`define WDRC_FREQ_SOFTWARE_OVERRIDE       2
`define WDRC_TM_COUNT_HI       5
`define WDRC_TM_COUNT_LO       1
`define WDRC_TM_UNIT           0
`define WDRC_WC_USB_DRV        7
`define WDRC_WC_PCI_CLOCK_DRIVE_HIGH        6
`define WDRC_WC_AGP_DRV        5
`define WDRC_WC_RST_TO         4
`define WDRC_WC_RST_FC         3
`define WDRC_WC_FLAG           2
`define WDRC_WC_DOG_EN         1
`define WDRC_SK_CPU_HI         7
`define WDRC_SK_CPU_LO         5
`define WDRC_SK_PCI_HI         3
`define WDRC_SK_PCI_LO         2
`define WDRC_SK_AGP_HI         1
`define WDRC_SK_AGP_LO         0
`define WDRC_RM_SRC            7
`define WDRC_RM_M_HI           6
`define WDRC_RM_M_LO           0

// ****************************************************************
// Reset values
// ****************************************************************
`define WDRC_RST_COUNT         5'h1f
`define WDRC_RST_BYTE          8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define WDRC_CLK_MHZ           250
`define WDRC_SHORT_UNIT_MS     150
`define WDRC_LONG_UNIT_MS      2500
`define WDRC_SHORT_UNIT_CYC    (`WDRC_SHORT_UNIT_MS * 1000 * `WDRC_CLK_MHZ)
`define WDRC_LONG_UNIT_CYC     (`WDRC_LONG_UNIT_MS * 1000 * `WDRC_CLK_MHZ)
`define WDRC_RST_PULSE_NS      1000
`define WDRC_RST_PULSE_CYC     ((`WDRC_RST_PULSE_NS * `WDRC_CLK_MHZ + 999) / 1000)

`endif

// [pkg/wdrc_pkg.sv]
// Types of the watchdog and recovery control byte logic
package wdrc_pkg;

   // ****************************************************************
   // Watchdog states
   // ****************************************************************
   typedef enum logic [1:0] {
      WDRC_IDLE,
      WDRC_ARMED,
      WDRC_EXPIRED
   } wdrc_state_e;

   // ****************************************************************
   // Output drive and skew selects
   // ****************************************************************
   typedef struct packed {
      logic usb_clock_drive_high;
      logic pci_clock_drive_high;
      logic agp_clock_drive_high;
   } wdrc_drive_s;

   typedef struct packed {
      logic [2:0] cpu_output_delay;
      logic [1:0] pci_output_delay;
      logic [1:0] agp_output_delay;
   } wdrc_skew_s;

   // ****************************************************************
   // Recovery frequency settings
   // ****************************************************************
   typedef struct packed {
      logic       recovery_source_select;
      logic [7:0] recovery_n_divider;
      logic [6:0] recovery_m_divider;
   } wdrc_recovery_s;

endpackage

// [verilog/wdrc_pulse_stretch.sv]
// Stretches a one-cycle trigger into a reset pulse of fixed width
module wdrc_pulse_stretch #(
   parameter int unsigned WIDTH_CYC = 32'd250
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Trigger and pulse
   input  wire logic trigger,
   output logic      pulse_ff
);

   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;

   // A trigger during a pulse restarts the full width
   always_comb begin
      nxt_cnt = cnt_ff;
      if (trigger)
         nxt_cnt = WIDTH_CYC[31:0];
      else if (cnt_ff != 32'h0)
         nxt_cnt = cnt_ff - 32'h1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_ff   <= 32'h0;
         pulse_ff <= 1'b0;
      end else begin
         cnt_ff   <= nxt_cnt;
         pulse_ff <= (nxt_cnt != 32'h0);
      end
   end

endmodule // wdrc_pulse_stretch

// [verilog/wdrc_unit_ticker.sv]
// Prescaler that emits one pulse per watchdog time unit
module wdrc_unit_ticker #(
   parameter int unsigned SHORT_CYC = 32'd37500000,
   parameter int unsigned LONG_CYC  = 32'd625000000
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Control
   input  wire logic run,
   input  wire logic long_unit,
   // Unit pulse
   output logic      tick
);

   logic [31:0] cnt_ff;
   logic [31:0] limit;

   assign limit = long_unit ? LONG_CYC[31:0] : SHORT_CYC[31:0];

   // Restarts from zero whenever the watchdog is not counting
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 32'h0;
         tick   <= 1'b0;
      end else if (!run) begin
         cnt_ff <= 32'h0;
         tick   <= 1'b0;
      end else if (cnt_ff >= limit - 32'h1) begin
         cnt_ff <= 32'h0;
         tick   <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 32'h1;
         tick   <= 1'b0;
      end
   end

endmodule // wdrc_unit_ticker

// [verilog/wdrc_watchdog_recovery_control.sv]
// Watchdog, recovery frequency and output select control bytes
// Functional notes
// - Five-bit timeout count in timer byte bits 5..1, all ones at reset.
// - Short unit gives timeouts 150 ms to 4.65 s, one unit a step.
// - Unit select 0 picks 150 ms, 1 picks 2.5 s (2.5 to 77.5 s).
// - Count reaching zero sets timeout flag; reset pulse only if enabled.
// - Control bit 4 enables reset pulse on timeout; default 0.
// - Control bit 3 enables reset pulse after any frequency change.
// - Flag bit 2 reads 1 after timeout; write 1 clears, 0 ignored.
// - Watchdog enable 0 stops the timer and reloads the count.
// - Enabled watchdog starts counting only after a frequency change.
// - Timeout resets system if bit 4 is set, loads recovery frequency, locks recovery mode.
// - In recovery mode host frequency changing writes are ignored.
// - Three drive bits for 48 MHz, PCI, 66 MHz outputs; 1 is high.
// - Three-bit CPU skew: nominal, three advance steps, four delay steps.
// - Eight-bit recovery N divider with M sets recovery CPU frequency.
// - Recovery ratio from latched straps, or software select when override.
// - Recovery source select picks latched straps or programmed dividers.
// - Override bit picks straps when 0, software select when 1.
`include "wdrc_params.svh"

module wdrc_watchdog_recovery_control #(
   parameter int unsigned SHORT_UNIT_CYC = `WDRC_SHORT_UNIT_CYC,
   parameter int unsigned LONG_UNIT_CYC  = `WDRC_LONG_UNIT_CYC
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Control byte access from the serial engine
   input  wire logic                    wr_en,
   input  wire logic [7:0]              wr_addr,
   input  wire logic [7:0]              wr_data,
   input  wire logic [7:0]              rd_addr,
   output logic      [7:0]              rd_data_ff,
   // Frequency logic
   input  wire logic                    freq_change_pulse,
   input  wire logic [4:0]              sw_freq_select,
   input  wire logic [4:0]              strap_freq_inputs,
   output logic                         freq_write_lock_ff,
   output logic                         recovery_load_ff,
   output wdrc_pkg::wdrc_recovery_s     recovery_ff,
   output logic      [4:0]              ratio_select_ff,
   // System reset
   output logic                         sys_reset_pulse_ff,
   // Output buffers
   output wdrc_pkg::wdrc_drive_s        drive_ff,
   output wdrc_pkg::wdrc_skew_s         skew_ff
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   wdrc_pkg::wdrc_state_e state_ff;
   wdrc_pkg::wdrc_state_e nxt_state;
   logic [4:0]            timeout_count_ff;
   logic                  timer_unit_select_ff;
   logic                  reset_on_timeout_enable_ff;
   logic                  reset_on_freq_change_enable_ff;
   logic                  timeout_flag_ff;
   logic                  dog_enable_ff;
   logic                  freq_software_override_ff;
   logic [4:0]            dog_count_ff;
   logic [4:0]            nxt_dog_count;
   logic [4:0]            strap_meta_ff;
   logic [4:0]            strap_sync_ff;
   logic [4:0]            strap_latched_ff;
   logic [1:0]            strap_wait_ff;
   logic                  strap_done_ff;
   logic                  unit_tick;
   logic                  timeout_evt;
   logic                  reset_trigger;
   logic                  wr_timer;
   logic                  wr_wdctl;
   logic                  wr_skew;
   logic                  wr_rec_n;
   logic                  wr_rec_m;
   logic                  wr_freq_sel;
   logic [7:0]            rd_mux;

   // ****************************************************************
   // Write decode
   // ****************************************************************
   // The reserved byte and unmapped offsets decode to nothing
   assign wr_timer    = wr_en && (wr_addr == `WDRC_OFS_TIMER);
   assign wr_wdctl    = wr_en && (wr_addr == `WDRC_OFS_WDCTL);
   assign wr_skew     = wr_en && (wr_addr == `WDRC_OFS_SKEW);
   assign wr_rec_n    = wr_en && (wr_addr == `WDRC_OFS_REC_N);
   assign wr_rec_m    = wr_en && (wr_addr == `WDRC_OFS_REC_M);
   assign wr_freq_sel = wr_en && (wr_addr == `WDRC_OFS_FREQ_SEL);

   // ****************************************************************
   // Timer byte
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timeout_count_ff     <= `WDRC_RST_COUNT;
         timer_unit_select_ff <= 1'b0;
      end else if (wr_timer) begin
         timeout_count_ff     <= wr_data[`WDRC_TM_COUNT_HI:`WDRC_TM_COUNT_LO];
         timer_unit_select_ff <= wr_data[`WDRC_TM_UNIT];
      end
   end

   // ****************************************************************
   // Watchdog control byte
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         drive_ff                       <= '0;
         reset_on_timeout_enable_ff     <= 1'b0;
         reset_on_freq_change_enable_ff <= 1'b0;
         dog_enable_ff                  <= 1'b0;
      end else if (wr_wdctl) begin
         drive_ff.usb_clock_drive_high  <= wr_data[`WDRC_WC_USB_DRV];
         drive_ff.pci_clock_drive_high  <= wr_data[`WDRC_WC_PCI_CLOCK_DRIVE_HIGH];
         drive_ff.agp_clock_drive_high  <= wr_data[`WDRC_WC_AGP_DRV];
         reset_on_timeout_enable_ff     <= wr_data[`WDRC_WC_RST_TO];
         reset_on_freq_change_enable_ff <= wr_data[`WDRC_WC_RST_FC];
         dog_enable_ff                  <= wr_data[`WDRC_WC_DOG_EN];
      end
   end

   // A timeout in the same cycle as a clearing write keeps the flag set
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         timeout_flag_ff <= 1'b0;
      else if (timeout_evt)
         timeout_flag_ff <= 1'b1;
      else if (wr_wdctl && wr_data[`WDRC_WC_FLAG])
         timeout_flag_ff <= 1'b0;
   end

   // ****************************************************************
   // Skew byte
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         skew_ff <= '0;
      end else if (wr_skew) begin
         skew_ff.cpu_output_delay <= wr_data[`WDRC_SK_CPU_HI:`WDRC_SK_CPU_LO];
         skew_ff.pci_output_delay <= wr_data[`WDRC_SK_PCI_HI:`WDRC_SK_PCI_LO];
         skew_ff.agp_output_delay <= wr_data[`WDRC_SK_AGP_HI:`WDRC_SK_AGP_LO];
      end
   end

   // ****************************************************************
   // Recovery divider bytes
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         recovery_ff.recovery_n_divider     <= `WDRC_RST_BYTE;
         recovery_ff.recovery_source_select <= 1'b0;
         recovery_ff.recovery_m_divider     <= 7'h0;
      end else begin
         if (wr_rec_n)
            recovery_ff.recovery_n_divider <= wr_data;
         if (wr_rec_m) begin
            recovery_ff.recovery_source_select <= wr_data[`WDRC_RM_SRC];
            recovery_ff.recovery_m_divider     <= wr_data[`WDRC_RM_M_HI:`WDRC_RM_M_LO];
         end
      end
   end

   // ****************************************************************
   // Frequency select byte
   // ****************************************************************
   // The override changes the output frequency, so it is frozen in recovery
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         freq_software_override_ff <= 1'b0;
      else if (wr_freq_sel && !freq_write_lock_ff)
         freq_software_override_ff <= wr_data[`WDRC_FREQ_SOFTWARE_OVERRIDE];
   end

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strap_meta_ff <= 5'h0;
         strap_sync_ff <= 5'h0;
      end else begin
         strap_meta_ff <= strap_freq_inputs;
         strap_sync_ff <= strap_meta_ff;
      end
   end

   // Straps are taken once, after the synchroniser has filled past reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strap_wait_ff    <= 2'h0;
         strap_done_ff    <= 1'b0;
         strap_latched_ff <= 5'h0;
      end else if (!strap_done_ff) begin
         strap_wait_ff <= strap_wait_ff + 2'h1;
         if (strap_wait_ff == 2'h2) begin
            strap_done_ff    <= 1'b1;
            strap_latched_ff <= strap_sync_ff;
         end
      end
   end

   // ****************************************************************
   // Watchdog sequencer
   // ****************************************************************
   wdrc_unit_ticker #(
      .SHORT_CYC (SHORT_UNIT_CYC),
      .LONG_CYC  (LONG_UNIT_CYC)
   ) u_ticker (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .run       (state_ff == wdrc_pkg::WDRC_ARMED),
      .long_unit (timer_unit_select_ff),
      .tick      (unit_tick)
   );

   // A programmed count of zero expires at the first unit
   assign timeout_evt = (state_ff == wdrc_pkg::WDRC_ARMED) && unit_tick && (dog_count_ff <= 5'h1);

   always_comb begin
      nxt_state     = state_ff;
      nxt_dog_count = dog_count_ff;
      case (state_ff)
         wdrc_pkg::WDRC_IDLE: begin
            nxt_dog_count = timeout_count_ff;
            if (dog_enable_ff && freq_change_pulse)
               nxt_state = wdrc_pkg::WDRC_ARMED;
         end
         wdrc_pkg::WDRC_ARMED: begin
            if (timeout_evt) begin
               nxt_dog_count = 5'h0;
               nxt_state     = wdrc_pkg::WDRC_EXPIRED;
            end else if (unit_tick) begin
               nxt_dog_count = dog_count_ff - 5'h1;
            end
         end
         wdrc_pkg::WDRC_EXPIRED: nxt_dog_count = 5'h0;
         default: nxt_state = wdrc_pkg::WDRC_IDLE;
      endcase
      if (!dog_enable_ff) begin
         nxt_state     = wdrc_pkg::WDRC_IDLE;
         nxt_dog_count = timeout_count_ff;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_ff     <= wdrc_pkg::WDRC_IDLE;
         dog_count_ff <= `WDRC_RST_COUNT;
      end else begin
         state_ff     <= nxt_state;
         dog_count_ff <= nxt_dog_count;
      end
   end

   // ****************************************************************
   // Recovery mode
   // ****************************************************************
   // Only clearing the enable releases the lock; a timeout still wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         freq_write_lock_ff <= 1'b0;
         recovery_load_ff   <= 1'b0;
      end else begin
         freq_write_lock_ff <= timeout_evt || (freq_write_lock_ff && dog_enable_ff);
         recovery_load_ff   <= timeout_evt;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         ratio_select_ff <= 5'h0;
      else
         ratio_select_ff <= freq_software_override_ff ? sw_freq_select : strap_latched_ff;
   end

   // ****************************************************************
   // System reset pulse
   // ****************************************************************
   assign reset_trigger = (timeout_evt && reset_on_timeout_enable_ff)
                       || (freq_change_pulse && reset_on_freq_change_enable_ff);

   wdrc_pulse_stretch #(
      .WIDTH_CYC (`WDRC_RST_PULSE_CYC)
   ) u_reset_pulse (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .trigger  (reset_trigger),
      .pulse_ff (sys_reset_pulse_ff)
   );

   // ****************************************************************
   // Read back
   // ****************************************************************
   always_comb begin
      rd_mux = 8'h0;
      case (rd_addr)
         `WDRC_OFS_FREQ_SEL: begin
            rd_mux[`WDRC_FS_STRAP_HI:`WDRC_FS_STRAP_LO] = strap_latched_ff;
            rd_mux[`WDRC_FREQ_SOFTWARE_OVERRIDE]                   = freq_software_override_ff;
         end
         `WDRC_OFS_TIMER: begin
            rd_mux[`WDRC_TM_COUNT_HI:`WDRC_TM_COUNT_LO] = timeout_count_ff;
            rd_mux[`WDRC_TM_UNIT]                       = timer_unit_select_ff;
         end
         `WDRC_OFS_WDCTL: begin
            rd_mux[`WDRC_WC_USB_DRV] = drive_ff.usb_clock_drive_high;
            rd_mux[`WDRC_WC_PCI_CLOCK_DRIVE_HIGH] = drive_ff.pci_clock_drive_high;
            rd_mux[`WDRC_WC_AGP_DRV] = drive_ff.agp_clock_drive_high;
            rd_mux[`WDRC_WC_RST_TO]  = reset_on_timeout_enable_ff;
            rd_mux[`WDRC_WC_RST_FC]  = reset_on_freq_change_enable_ff;
            rd_mux[`WDRC_WC_FLAG]    = timeout_flag_ff;
            rd_mux[`WDRC_WC_DOG_EN]  = dog_enable_ff;
         end
         `WDRC_OFS_SKEW: begin
            rd_mux[`WDRC_SK_CPU_HI:`WDRC_SK_CPU_LO] = skew_ff.cpu_output_delay;
            rd_mux[`WDRC_SK_PCI_HI:`WDRC_SK_PCI_LO] = skew_ff.pci_output_delay;
            rd_mux[`WDRC_SK_AGP_HI:`WDRC_SK_AGP_LO] = skew_ff.agp_output_delay;
         end
         `WDRC_OFS_REC_N: rd_mux = recovery_ff.recovery_n_divider;
         `WDRC_OFS_REC_M: begin
            rd_mux[`WDRC_RM_SRC]               = recovery_ff.recovery_source_select;
            rd_mux[`WDRC_RM_M_HI:`WDRC_RM_M_LO] = recovery_ff.recovery_m_divider;
         end
         default: rd_mux = 8'h0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         rd_data_ff <= 8'h0;
      else
         rd_data_ff <= rd_mux;
   end

endmodule // wdrc_watchdog_recovery_control
